/* File: hdl/keypad_wake_interrupt.sv */
// Purpose: Six-input keypad interrupt with auto-wakeup source and AXI4-Lite registers.
// Assumes: Vector fetch and break inputs are synchronous to aclk at 20 MHz; pins pass a two-stage synchroniser.
// Notes: Status/control at word index 0x1a, input enable at word index 0x1b.
//
// Behaviour
// - Six pins, each enabled as keypad interrupt input by its own bit.
// - An enabled pin has its pullup on regardless of port pullup setting.
// - Latch a request when an enabled input falls after all were high.
// - Edge mode: no new request while another enabled input is low.
// - Level mode: request stays while any enabled input is low.
// - Level mode: clear needs acknowledge and all inputs high, any order.
// - Vector fetch and software acknowledge write both acknowledge the request.
// - A falling edge after acknowledge latches a fresh request.
// - Unmasked pending request drives the CPU interrupt for vector FFE0/FFE1.
// - Auto-wakeup request clears only by software acknowledge or reset.
// - Edge mode: acknowledge clears the keypad request at once.
// - Reset clears the request and trigger mode even with input low.
// - Pending flag shows keypad or auto-wakeup request, independent of mask.
// - Status bits 7 to 4 read as zero.
// - Acknowledge bit is write-only, reads zero, writing one clears requests.
// - Mask bit set blocks requests from the CPU; reset clears it.
// - Trigger mode one is edge plus level, zero edge only, for all sources.
// - Enable bit forces pin to input; reading still needs direction zero.
// - In break, software acknowledge ignored unless break clear enable; clears persist.
// - Block stays active in wait and stop; unmasked request wakes CPU.
// - Reset clears the whole input enable register.
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "kwi_defs.svh"
module keypad_wake_interrupt (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [`KWI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [`KWI_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Keypad pins and port settings
  input wire logic [`KWI_KEYS-1:0] key_pins,
  input wire logic [`KWI_KEYS-1:0] port_pullup_enable_bit,
  input wire logic [`KWI_KEYS-1:0] port_direction_bits,
  output logic [`KWI_KEYS-1:0] pullup_on,
  output logic [`KWI_KEYS-1:0] force_input,
  output logic [`KWI_KEYS-1:0] pin_read_allowed,
  // Auto-wakeup source
  input wire logic auto_wakeup_request,
  // CPU and system integration unit
  input wire logic vector_fetch,
  input wire logic break_state,
  input wire logic break_clear_enable,
  output logic cpu_irq,
  output logic wake_request
);
  // Registers.
  logic mode_q;
  logic mask_q;
  logic [`KWI_KEYS-1:0] key_en_q;
  logic awu_en_q;
  logic key_latch_q;
  logic any_low_q;

  // Bus state.
  logic aw_have_q;
  logic w_have_q;
  logic [`KWI_ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;

  logic [`KWI_KEYS-1:0] keys_s;
  logic awu_pending;

  // Word index of a byte address; registers take one aligned word each.
  function automatic logic hits(input logic [`KWI_ADDR_W-1:0] addr, input logic [9:0] idx);
    hits = (addr[`KWI_ADDR_W-1:2] == idx);
  endfunction

  key_sync u_key_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .keys(key_pins),
    .keys_sync(keys_s)
  );

  // Pin side effects of the enable bits; read permission follows the direction bits alone.
  assign pullup_on = key_en_q | port_pullup_enable_bit;
  assign force_input = key_en_q;
  assign pin_read_allowed = ~port_direction_bits;

  // Write channel decode.
  wire wr_go = aw_have_q && w_have_q && !bvalid_q;
  wire wr_status = hits(awaddr_q, `KWI_IDX_STATUS);
  wire wr_enable = hits(awaddr_q, `KWI_IDX_ENABLE);
  wire wr_mapped = wr_status || wr_enable;
  wire wr_lane0 = wstrb_q[`KWI_LANE0];
  wire wr_status_go = wr_go && wr_status && wr_lane0;
  wire wr_enable_go = wr_go && wr_enable && wr_lane0;

  // Acknowledge sources; break protection only gates the software path.
  wire ack_written = wr_status_go && wdata_q[`KWI_BIT_ACK];
  wire ack_allowed = !break_state || break_clear_enable;
  wire sw_ack = ack_written && ack_allowed;
  wire kb_ack = vector_fetch || sw_ack;

  // Keypad detection on the synchronised inputs.
  wire [`KWI_KEYS-1:0] low_enabled = ~keys_s & key_en_q;
  wire any_low = |low_enabled;
  wire kb_event = any_low && !any_low_q;
  wire key_latch_d = kb_event || (key_latch_q && !kb_ack);
  wire kb_req = key_latch_q || (mode_q && any_low);

  awu_latch u_awu_latch (
    .aclk(aclk),
    .aresetn(aresetn),
    .wake_req(auto_wakeup_request),
    .wake_en(awu_en_q),
    .level_mode(mode_q),
    .sw_ack(sw_ack),
    .wake_pending(awu_pending)
  );

  // Pending flag ignores the mask so that polling works.
  wire pending = kb_req || awu_pending;
  assign cpu_irq = pending && !mask_q;
  assign wake_request = cpu_irq;

  // Read path.
  wire rd_go = s_axi_arvalid && !rvalid_q;
  wire rd_status = hits(s_axi_araddr, `KWI_IDX_STATUS);
  wire rd_enable = hits(s_axi_araddr, `KWI_IDX_ENABLE);
  wire [7:0] status_view = {4'h0, pending, 1'b0, mask_q, mode_q};
  wire [7:0] enable_view = {1'b0, awu_en_q, key_en_q};
  wire [7:0] rd_byte = rd_status ? status_view : (rd_enable ? enable_view : `KWI_RESET_BYTE);
  wire rd_mapped = rd_status || rd_enable;

  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready = !w_have_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;

  // Keypad latch and edge history.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      key_latch_q <= 1'b0;
      any_low_q <= 1'b0;
    end else begin
      key_latch_q <= key_latch_d;
      any_low_q <= any_low;
    end
  end

  // Software-visible control bits.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q <= 1'b0;
      mask_q <= 1'b0;
      key_en_q <= {`KWI_KEYS{1'b0}};
      awu_en_q <= 1'b0;
    end else begin
      if (wr_status_go) begin
        mode_q <= wdata_q[`KWI_BIT_MODE];
        mask_q <= wdata_q[`KWI_BIT_MASK];
      end
      if (wr_enable_go) begin
        key_en_q <= wdata_q[`KWI_KEYS-1:0];
        awu_en_q <= wdata_q[`KWI_BIT_AWU];
      end
    end
  end

  // Write address and data are taken in either order and held until both are in.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_have_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (wr_go) begin
        w_have_q <= 1'b0;
      end
    end
  end

  // Write response; unmapped words answer SLVERR.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= kwi_pkg::resp_okay_t_val;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_mapped ? kwi_pkg::resp_okay_t_val : kwi_pkg::resp_slverr_t_val;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Read answer one cycle after the address is taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rresp_q <= kwi_pkg::resp_okay_t_val;
      rdata_q <= '0;
    end else if (rd_go) begin
      rvalid_q <= 1'b1;
      rresp_q <= rd_mapped ? kwi_pkg::resp_okay_t_val : kwi_pkg::resp_slverr_t_val;
      rdata_q <= {24'h000000, rd_byte};
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence ack_step;
    kb_ack && !kb_event;
  endsequence

  sequence released_step;
    !any_low;
  endsequence

  a_edge_latches: assert property (kb_event |=> key_latch_q)
    else $error("falling edge did not latch a keypad request");

  a_edge_blocked: assert property (any_low_q && !key_latch_q |=> !key_latch_q)
    else $error("request latched while an enabled input was already low");

  a_level_holds: assert property (mode_q && any_low |-> cpu_irq || mask_q)
    else $error("level request dropped while an input stayed low");

  a_level_clears: assert property (ack_step ##1 released_step ##0 mode_q |-> !kb_req)
    else $error("level request stayed after acknowledge and release");

  a_fetch_clears: assert property (vector_fetch && !kb_event |=> !key_latch_q)
    else $error("vector fetch did not clear the keypad latch");

  a_mask_gates: assert property (cpu_irq |-> !mask_q && pending)
    else $error("interrupt raised while masked or with nothing pending");

  a_break_guard: assert property (
    break_state && !break_clear_enable && ack_written && !vector_fetch && key_latch_q
    |=> key_latch_q)
    else $error("acknowledge took effect during protected break");

  a_ack_reads_zero: assert property (
    rd_go && rd_status |=> rdata_q[`KWI_BIT_ACK] == 1'b0)
    else $error("acknowledge bit read nonzero");

  a_word_upper: assert property (rvalid_q |-> rdata_q[31:8] == 24'h000000)
    else $error("upper read data bits nonzero");

  a_read_latency: assert property (rd_go |=> rvalid_q [*1] ##0 rdata_q[7:0] == $past(rd_byte))
    else $error("read data not answered one cycle after the address");

  a_pullup_follows: assert property (&(pullup_on | ~key_en_q))
    else $error("enabled pin has no pullup");

  a_sw_ack_clears: assert property (sw_ack && !kb_event |=> !key_latch_q)
    else $error("software acknowledge did not clear the keypad latch");

  a_level_either: assert property (
    released_step ##1 ack_step ##1 released_step ##0 mode_q |-> !kb_req)
    else $error("level request stayed after release then acknowledge");

  a_break_release: assert property (
    break_state && break_clear_enable && ack_written && !kb_event |=> !key_latch_q)
    else $error("permitted acknowledge during break did not clear the latch");

  a_edge_single: assert property (kb_event |=> !kb_event)
    else $error("one falling edge produced two events");

  a_awu_survives: assert property (
    awu_pending && !mode_q && !sw_ack |=> awu_pending)
    else $error("auto-wakeup request dropped without software acknowledge");

  a_flag_polls: assert property (
    rd_go && rd_status |=> rdata_q[`KWI_BIT_FLAG] == $past(pending))
    else $error("pending flag read differs from the pending request");

  a_status_upper: assert property (rd_go && rd_status |=> rdata_q[7:4] == 4'h0)
    else $error("unused status bits read nonzero");

  a_wake_unmasked: assert property (pending && !mask_q |-> wake_request)
    else $error("unmasked request did not raise the wake request");

  a_input_forced: assert property (&(force_input | ~key_en_q))
    else $error("enabled pin not forced to input");

  a_mode_writes: assert property (
    wr_status_go |=> mode_q == $past(wdata_q[`KWI_BIT_MODE]))
    else $error("trigger mode bit did not take the written value");

  a_mask_writes: assert property (
    wr_status_go |=> mask_q == $past(wdata_q[`KWI_BIT_MASK]))
    else $error("mask bit did not take the written value");

  a_write_answers: assert property (wr_go |=> s_axi_bvalid)
    else $error("write response missing after the write");

  a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write channel ready while a response is open");

  a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address ready while read data is open");

  // The reset checks name their own disable so that they can watch the reset cycle itself.
  a_reset_clears: assert property (@(posedge aclk) disable iff (1'b0)
    !aresetn |=> !key_latch_q && !mode_q && !mask_q)
    else $error("reset left the request, mode or mask set");

  a_enable_reset: assert property (@(posedge aclk) disable iff (1'b0)
    !aresetn |=> key_en_q == {`KWI_KEYS{1'b0}} && !awu_en_q)
    else $error("reset left an input enable bit set");
endmodule

/* File: hdl/kwi_defs.svh */
// Purpose: Named offsets, bit positions and reset values of the keypad wake interrupt block.
// Assumes: Registers sit at word index times four on the AXI4-Lite bus.
// Notes: Definitions only.
`ifndef KWI_DEFS_SVH
`define KWI_DEFS_SVH

`define KWI_KEYS 6
`define KWI_ADDR_W 12
`define KWI_IDX_STATUS 10'h01a
`define KWI_IDX_ENABLE 10'h01b
`define KWI_BIT_MODE 0
`define KWI_BIT_MASK 1
`define KWI_BIT_ACK 2
`define KWI_BIT_FLAG 3
`define KWI_BIT_AWU 6
`define KWI_RESET_BYTE 8'h00
`define KWI_KEY_IDLE 6'h3f
`define KWI_LANE0 0

`endif

/* File: hdl/kwi_pkg.sv */
// Purpose: Types shared by the keypad wake interrupt design files.
// Assumes: Nothing beyond the header of constants.
// Notes: Types only; numbers live in the header.
package kwi_pkg;
  typedef logic [7:0] reg_byte_t;
  typedef logic [31:0] bus_word_t;
  typedef enum logic [1:0] {
    resp_okay_t_val = 2'h0,
    resp_slverr_t_val = 2'h2
  } resp_t;
endpackage

/* File: hdl/key_sync.sv */
// Purpose: Two-stage synchroniser for the six keypad inputs.
// Assumes: Pins idle high through their pullups.
// Notes: Only the second stage is visible outside.
`timescale 1ns/1ps
`include "kwi_defs.svh"
module key_sync (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Pins and synchronised copy
  input wire logic [`KWI_KEYS-1:0] keys,
  output logic [`KWI_KEYS-1:0] keys_sync
);
  logic [`KWI_KEYS-1:0] meta_q;
  logic [`KWI_KEYS-1:0] stable_q;

  // Reset to the idle level so that release of reset cannot fake a falling edge.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= `KWI_KEY_IDLE;
      stable_q <= `KWI_KEY_IDLE;
    end else begin
      meta_q <= keys;
      stable_q <= meta_q;
    end
  end

  assign keys_sync = stable_q;
endmodule

/* File: hdl/awu_latch.sv */
// Purpose: Latch for the auto-wakeup request input.
// Assumes: The request input is synchronous to aclk.
// Notes: Only a software acknowledge or reset empties the latch.
`timescale 1ns/1ps
module awu_latch (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Request and control
  input wire logic wake_req,
  input wire logic wake_en,
  input wire logic level_mode,
  input wire logic sw_ack,
  // Result
  output logic wake_pending
);
  logic prev_q;
  logic latch_q;
  wire rise = wake_en && wake_req && !prev_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_q <= 1'b0;
      latch_q <= 1'b0;
    end else begin
      prev_q <= wake_req && wake_en;
      // A new request beats an acknowledge in the same cycle.
      latch_q <= rise || (latch_q && !sw_ack);
    end
  end

  assign wake_pending = latch_q || (level_mode && wake_en && wake_req);

  a_awu_holds: assert property (@(posedge aclk) disable iff (!aresetn)
    latch_q && !sw_ack |=> latch_q)
    else $error("auto-wakeup latch cleared without software acknowledge");
endmodule

/* File: verif/key_switches.sv */
// Purpose: Model of the keys or switches wired to the keypad pins.
// Assumes: Each pin has a pullup, so a released key reads high.
// Notes: A closed key pulls its pin to ground.
`timescale 1ns/1ps
module key_switches (
  // Key state from the bench
  input wire logic [5:0] pressed,
  // Pins
  output logic [5:0] key_pins
);
  // A released pin is not left floating; the pullup takes it high.
  assign key_pins = ~pressed;
endmodule

/* File: verif/tb_keypad_wake_interrupt.sv */
// Purpose: Self-checking bench for the keypad wake interrupt block.
// Assumes: Registers at byte 0x68 and 0x6c; a pin change reaches cpu_irq in three cycles in edge mode, two in level mode.
// Notes: Pin waits are a few cycles longer than the three-cycle latency.
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fails++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tb_keypad_wake_interrupt;
  localparam logic [11:0] ST = 12'h068;
  localparam logic [11:0] EN = 12'h06c;
  logic aclk = 0, aresetn = 0;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, auto_wakeup_request = 0, vector_fetch = 0, cpu_irq, wake_request;
  logic break_state = 0, break_clear_enable = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic [1:0] s_axi_bresp, s_axi_rresp, r, b;
  logic [5:0] key_pins, pressed = 0, pullup_on, force_input, pin_read_allowed;
  logic [5:0] port_pullup_enable_bit = 6'h01, port_direction_bits = 6'h05;
  int fails = 0, compares = 0, cyc = 0;
  always #25 aclk = ~aclk;
  key_switches sw (.pressed, .key_pins);
  keypad_wake_interrupt DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .key_pins,
    .port_pullup_enable_bit, .port_direction_bits, .pullup_on, .force_input,
    .pin_read_allowed, .auto_wakeup_request, .vector_fetch, .break_state,
    .break_clear_enable, .cpu_irq, .wake_request);
  task automatic end_of_test();
    if (fails == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // Address and data are offered together; each is dropped once taken.
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    logic ka, kw;
    ka = 0;
    kw = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, v};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (!(ka && kw)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin ka = 1; s_axi_awvalid <= 0; end
      if (s_axi_wvalid && s_axi_wready) begin kw = 1; s_axi_wvalid <= 0; end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    b = s_axi_bresp;
    s_axi_bready <= 0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 0;
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 0;
  endtask
  task automatic fetch();
    vector_fetch <= 1;
    tick(1);
    vector_fetch <= 0;
    tick(2);
  endtask
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      end_of_test();
    end
  end
  initial begin
    tick(10);
    aresetn <= 1;
    rd(ST); `CHK(d, 32'h0)
    rd(EN); `CHK(d, 32'h0)
    rd(12'h100); `CHK(r, 2'h2)
    wr(12'h100, 8'h3f); `CHK(b, 2'h2)
    // Masked start-up keeps a settling pin from raising a false request.
    wr(ST, 8'h02); wr(EN, 8'h3f); wr(ST, 8'h06); wr(ST, 8'h00);
    `CHK(b, 2'h0)
    `CHK(force_input, 6'h3f)
    `CHK(pin_read_allowed, 6'h3a)
    `CHK(pullup_on, 6'h3f)
    pressed <= 6'h01; tick(5);
    `CHK(cpu_irq, 1'b1)
    `CHK(wake_request, 1'b1)
    rd(ST); `CHK(d, 32'h08)
    wr(ST, 8'h04); tick(1); `CHK(cpu_irq, 1'b0)
    pressed <= 6'h03; tick(5); `CHK(cpu_irq, 1'b0)
    pressed <= 6'h00; tick(5); pressed <= 6'h04; tick(5);
    `CHK(cpu_irq, 1'b1)
    fetch(); `CHK(cpu_irq, 1'b0)
    pressed <= 6'h00; wr(ST, 8'h02); pressed <= 6'h08; tick(5);
    `CHK(cpu_irq, 1'b0)
    rd(ST); `CHK(d, 32'h0a)
    pressed <= 6'h00; tick(5); wr(ST, 8'h06); wr(ST, 8'h01);
    pressed <= 6'h10; tick(5); `CHK(cpu_irq, 1'b1)
    wr(ST, 8'h05); tick(2); `CHK(cpu_irq, 1'b1)
    pressed <= 6'h00; tick(5); `CHK(cpu_irq, 1'b0)
    wr(ST, 8'h00); break_state <= 1; pressed <= 6'h20; tick(5);
    wr(ST, 8'h04); tick(1); `CHK(cpu_irq, 1'b1)
    break_clear_enable <= 1; wr(ST, 8'h04); break_state <= 0; tick(2);
    `CHK(cpu_irq, 1'b0)
    pressed <= 6'h00; break_clear_enable <= 0; wr(EN, 8'h40);
    `CHK(force_input, 6'h00)
    `CHK(pullup_on, 6'h01)
    auto_wakeup_request <= 1; tick(3);
    fetch(); `CHK(cpu_irq, 1'b1)
    auto_wakeup_request <= 0; wr(ST, 8'h04); tick(1);
    `CHK(cpu_irq, 1'b0)
    wr(EN, 8'h01); wr(ST, 8'h01); pressed <= 6'h01; tick(5);
    `CHK(cpu_irq, 1'b1)
    aresetn <= 0; tick(2); aresetn <= 1; tick(1);
    `CHK(cpu_irq, 1'b0)
    rd(ST); `CHK(d, 32'h0)
    rd(EN); `CHK(d, 32'h0)
    end_of_test();
  end
endmodule
